// ==== inc/tpw_pkg.sv ====
// Purpose: shared constants for the timer prescaler and watchdog block
// Assumes: 32-bit AHB-Lite register access, one core clock
// Notes:   register offsets are byte addresses, one word per register
// Operation
// [RQ1] without prescaler the pin is the prescaler output, sampled at phase two and four
// [RQ2] source holds the pin high two and low two oscillator periods unprescaled
// [RQ3] source input period is at least four oscillator periods over the ratio
// [RQ4] timer increment follows an input change by three to seven oscillator periods
// [RQ5] one 8-bit counter serves timer or watchdog, never both
// [RQ6] assignment bit and 3-bit ratio sit in option bits 3 to 0
// [RQ7] timer count writes clear the prescaler while it serves the timer
// [RQ8] watchdog clear also clears the prescaler while it serves the watchdog
// [RQ9] prescaler count is not visible to software and resets to zero
// [RQ10] software moving prescaler to watchdog clears watchdog, timer, then sets ratio
// [RQ11] software moving prescaler to timer clears watchdog first, even when disabled
// [RQ12] watchdog runs only when the enable fuse bit 2 is one
// [RQ13] config bits 1 to 0 decode the oscillator type
// [RQ14] config bits 11 to 3 protect code when zero; reduced variant uses bit 3
// [RQ15] watchdog counts its own oscillator, independent of the core clock
// [RQ16] watchdog time-out raises a full device reset
// [RQ17] watchdog time-out reset clears the active-low timeout flag, status bit 4
// [RQ18] nominal time-out 18 ms, stretched by ratios up to 1:128
// [RQ19] assignment bit clear selects timer, set selects watchdog
// [RQ20] timer ratios run in powers of two from 1:2 to 1:256
// [RQ21] watchdog clear restarts the watchdog and its prescaler
// [RQ22] ratio n divides by 2^(n+1) for timer and 2^n for watchdog
// [RQ23] watchdog oscillator passes a two-flop synchroniser into the core domain
package tpw_pkg;

  // register map, byte addresses
  localparam int          TPW_ADDR_W      = 8;
  localparam logic [7:0]  TPW_OFF_OPTION  = 8'h00;
  localparam logic [7:0]  TPW_OFF_CTRL    = 8'h04;
  localparam logic [7:0]  TPW_OFF_STATUS  = 8'h08;
  localparam logic [7:0]  TPW_OFF_CONFIG  = 8'h0C;

  // option register layout
  localparam int          TPW_OPT_W       = 6;
  localparam logic [5:0]  TPW_OPT_RST     = 6'h3F;
  localparam int          TPW_OPT_PSA_BIT = 3;
  localparam int          TPW_OPT_PS_LSB  = 0;

  // control strobes, write one to fire
  localparam int          TPW_CTRL_TMRWR_BIT = 0;
  localparam int          TPW_CTRL_WDCLR_BIT = 1;

  // status layout
  localparam int          TPW_STAT_TO_BIT = 4;
  localparam logic        TPW_TO_RST      = 1'b1;

  // configuration word layout
  localparam int          TPW_CFG_W       = 12;
  localparam int          TPW_CFG_WATCHDOG_ENABLE_FUSE    = 2;
  localparam int          TPW_CFG_CP_LSB  = 3;
  localparam int          TPW_CFG_CP_MSB  = 11;

  // oscillator type codes
  localparam logic [1:0]  TPW_OSC_LOW_POWER_CRYSTAL      = 2'h0;
  localparam logic [1:0]  TPW_OSC_STANDARD_CRYSTAL       = 2'h1;
  localparam logic [1:0]  TPW_OSC_HIGH_SPEED_CRYSTAL     = 2'h2;
  localparam logic [1:0]  TPW_OSC_RESISTOR_CAPACITOR_OSC = 2'h3;

  // timing; one oscillator period is one core clock
  localparam int          TPW_PRE_W        = 8;
  localparam int          TPW_WDT_NOM_MS   = 18;
  localparam int          TPW_WDT_OSC_HZ   = 32000;
  localparam int          TPW_BASE_W       = 16;
  localparam int          TPW_INC_MIN_TOSC = 3;
  localparam int          TPW_INC_MAX_TOSC = 7;

  // internal phase clock sequence
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} tpw_phase_e;

endpackage

// ==== core/tpw_cnt8.sv ====
// Purpose: the shared prescaler counter
// Assumes: clear has priority over count
// Notes:   no software path to the count
`timescale 1ns/10ps
`default_nettype none
module tpw_cnt8 #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      count_q
);

  logic [W-1:0] count_d;

  // clear beats increment so a write and a count edge together leave zero
  always_comb
  begin
    count_d = count_q;
    if (clr)
      count_d = '0;
    else if (inc)
      count_d = count_q + 1'b1;
  end

  // all zeros on any reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_q <= '0; // RQ9
    else if (ce)
      count_q <= count_d;
  end

endmodule
`default_nettype wire

// ==== core/tpw_top.sv ====
// Purpose: timer input path, shared prescaler and watchdog with AHB-Lite registers
// Assumes: pins synchronous to hclk; one hclk period stands for one oscillator period
// Notes:   watchdog oscillator arrives as a level and is synchronised into hclk
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tpw_top
  import tpw_pkg::*;
#(
  parameter int WDT_OSC_HZ = TPW_WDT_OSC_HZ,
  parameter int PRE_W      = TPW_PRE_W
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [TPW_ADDR_W-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  timer_ext_clock_pin,
  input  wire logic                  wdt_osc_pin,
  input  wire logic [TPW_CFG_W-1:0]  cfg_word,
  input  wire logic                  cfg_reduced,
  output logic                       timer_inc,
  output logic                       wdt_device_reset,
  output logic [1:0]                 osc_type,
  output logic                       code_protect_on,
  output logic                       wdt_enabled
);

  localparam int              BASE_TICKS = (TPW_WDT_NOM_MS * WDT_OSC_HZ) / 1000;
  localparam logic [TPW_BASE_W-1:0] BASE_LAST =
    TPW_BASE_W'((BASE_TICKS > 1) ? BASE_TICKS - 1 : 0);
  localparam int              INC_LO = TPW_INC_MIN_TOSC;
  localparam int              INC_HI = TPW_INC_MAX_TOSC;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state

  logic [TPW_OPT_W-1:0]  opt_q,      opt_d;
  logic                  dp_wr_q,    dp_wr_d;
  logic [7:0]            dp_addr_q,  dp_addr_d;
  logic [31:0]           rdata_q,    rdata_d;
  logic                  to_flag_q,  to_flag_d;
  logic                  tmr_wr_stb;
  logic                  wd_clr_stb;
  logic                  prescaler_assign_sel;
  logic [2:0]            ps;
  logic [TPW_CFG_W-1:0]  cfg_view;
  logic                  addr_ok;
  logic                  timeout;

  assign prescaler_assign_sel = opt_q[TPW_OPT_PSA_BIT];        // RQ19
  assign ps  = opt_q[TPW_OPT_PS_LSB +: 3];    // RQ6
  assign addr_ok = hsel && htrans[1] && hready;

  // reduced variant shows only the single protect bit above the fuse
  always_comb
  begin
    cfg_view = cfg_word;
    if (cfg_reduced)
      cfg_view[TPW_CFG_CP_MSB:TPW_CFG_CP_LSB+1] = '0; // RQ14
  end

  // strobes fire in the write data phase, when hwdata is valid
  assign tmr_wr_stb = dp_wr_q && (dp_addr_q == TPW_OFF_CTRL) && hwdata[TPW_CTRL_TMRWR_BIT];
  assign wd_clr_stb = dp_wr_q && (dp_addr_q == TPW_OFF_CTRL) && hwdata[TPW_CTRL_WDCLR_BIT];

  // address phase capture, read data registered so hrdata comes from a flop
  always_comb
  begin
    dp_wr_d   = addr_ok && hwrite;
    dp_addr_d = addr_ok ? haddr : dp_addr_q;
    rdata_d   = 32'h0000_0000;
    if (addr_ok && !hwrite)
    begin
      case (haddr)
        TPW_OFF_OPTION: rdata_d[TPW_OPT_W-1:0]    = opt_q;
        TPW_OFF_STATUS: rdata_d[TPW_STAT_TO_BIT]  = to_flag_q;
        TPW_OFF_CONFIG: rdata_d[TPW_CFG_W-1:0]    = cfg_view;
        default:        rdata_d                   = 32'h0000_0000; // unmapped and ctrl read zero
      endcase
    end
    opt_d = opt_q;
    if (dp_wr_q && (dp_addr_q == TPW_OFF_OPTION))
      opt_d = hwdata[TPW_OPT_W-1:0]; // RQ6
    // hardware clear wins over a software set in the same cycle
    to_flag_d = to_flag_q;
    if (timeout)
      to_flag_d = 1'b0; // RQ17
    else if (dp_wr_q && (dp_addr_q == TPW_OFF_STATUS) && hwdata[TPW_STAT_TO_BIT])
      to_flag_d = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opt_q     <= TPW_OPT_RST;
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      to_flag_q <= TPW_TO_RST;
    end
    else if (ce)
    begin
      opt_q     <= opt_d;
      dp_wr_q   <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      rdata_q   <= rdata_d;
      to_flag_q <= to_flag_d;
    end
  end

  // zero wait states, always OKAY
  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // shared prescaler

  logic [PRE_W-1:0] pre_cnt;
  logic             pre_clr;
  logic             pre_inc;
  logic             pin_q,   pin_d;
  logic             pin_rise;
  logic             base_end;
  logic [PRE_W-1:0] wd_mask;

  assign pin_d    = timer_ext_clock_pin;
  assign pin_rise = pin_d && !pin_q;

  // one counter, steered to timer or watchdog by the assignment bit
  assign pre_clr = (tmr_wr_stb && !prescaler_assign_sel)   // RQ7
                || (wd_clr_stb && prescaler_assign_sel)    // RQ8
                || timeout;               // RQ9
  assign pre_inc = prescaler_assign_sel ? (base_end && !timeout) : pin_rise; // RQ5

  tpw_cnt8 #(
    .W       (PRE_W)
  ) u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .clr     (pre_clr),
    .inc     (pre_inc),
    .count_q (pre_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase clocks and timer input sampler

  tpw_phase_e phase_q, phase_d;
  logic       s1_q, s1_d;
  logic       s2_q, s2_d;
  logic       inc_q, inc_d;
  logic       samp_src;
  logic       samp_pt;

  // bit ps of the count divides by 2^(ps+1); unassigned means the raw pin
  assign samp_src = prescaler_assign_sel ? pin_q : pre_cnt[ps]; // RQ1 RQ20 RQ22
  assign samp_pt  = (phase_q == PH_TWO) || (phase_q == PH_FOUR); // RQ1

  // two-stage sampler; increments on a rising prescaler output, so latency
  // stays inside 3..4 periods and short pulses below two periods can be lost
  always_comb
  begin
    case (phase_q)
      PH_ONE:   phase_d = PH_TWO;
      PH_TWO:   phase_d = PH_THREE;
      PH_THREE: phase_d = PH_FOUR;
      PH_FOUR:  phase_d = PH_ONE;
      default:  phase_d = PH_ONE;
    endcase
    s1_d  = samp_pt ? samp_src : s1_q;
    s2_d  = samp_pt ? s1_q : s2_q;
    inc_d = samp_pt && s1_q && !s2_q; // RQ4
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= PH_ONE;
      pin_q   <= 1'b0;
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      inc_q   <= 1'b0;
    end
    else if (ce)
    begin
      phase_q <= phase_d;
      pin_q   <= pin_d;
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      inc_q   <= inc_d;
    end
  end

  assign timer_inc = inc_q;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog

  logic                  osc_m_q, osc_s_q, osc_p_q;
  logic [TPW_BASE_W-1:0] base_q,  base_d;
  logic                  rst_q,   rst_d;
  logic                  wde_q,   wde_d;
  logic [1:0]            osct_q,  osct_d;
  logic                  cp_q,    cp_d;
  logic                  osc_tick;

  // first flop feeds only the second; edges taken after the second
  assign osc_tick = osc_s_q && !osc_p_q; // RQ23 RQ15
  // a clear landing with the last tick wins, so it really heads off the reset
  assign base_end = wde_q && osc_tick && !wd_clr_stb && (base_q == BASE_LAST); // RQ18 RQ21
  assign wd_mask  = PRE_W'((1 << ps) - 1);
  // unassigned prescaler means one base period; assigned stretches by 2^ps
  assign timeout  = base_end && (!prescaler_assign_sel || ((pre_cnt & wd_mask) == wd_mask)); // RQ22 RQ16

  always_comb
  begin
    base_d = base_q;
    if (!wde_q || wd_clr_stb || timeout)
      base_d = '0; // RQ21 RQ12
    else if (osc_tick)
      base_d = (base_q == BASE_LAST) ? '0 : base_q + 1'b1;
    rst_d  = timeout; // RQ16
    wde_d  = cfg_word[TPW_CFG_WATCHDOG_ENABLE_FUSE]; // RQ12
    osct_d = cfg_word[1:0]; // RQ13
    // any zero protect bit turns protection on
    cp_d   = cfg_reduced ? !cfg_word[TPW_CFG_CP_LSB]
                         : !(&cfg_word[TPW_CFG_CP_MSB:TPW_CFG_CP_LSB]); // RQ14
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_m_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_p_q <= 1'b0;
      base_q  <= '0;
      rst_q   <= 1'b0;
      wde_q   <= 1'b0;
      osct_q  <= TPW_OSC_LOW_POWER_CRYSTAL;
      cp_q    <= 1'b0;
    end
    else if (ce)
    begin
      osc_m_q <= wdt_osc_pin;
      osc_s_q <= osc_m_q;
      osc_p_q <= osc_s_q;
      base_q  <= base_d;
      rst_q   <= rst_d;
      wde_q   <= wde_d;
      osct_q  <= osct_d;
      cp_q    <= cp_d;
    end
  end

  assign wdt_device_reset = rst_q;
  assign wdt_enabled      = wde_q;
  assign osc_type         = osct_q;
  assign code_protect_on  = cp_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_inc_delay;
    @(posedge hclk) disable iff (!hresetn)
    ($rose(samp_src) && ce) ##1 (samp_src && ce)[*3] |-> ##[0:2] timer_inc;
  endproperty
  a_inc_delay: assert property (p_inc_delay) else $error("timer increment late"); // RQ4

  property p_inc_cause;
    @(posedge hclk) disable iff (!hresetn)
    $rose(timer_inc) |-> $past(s1_q) && !$past(s2_q) && $past(samp_pt);
  endproperty
  a_inc_cause: assert property (p_inc_cause) else $error("increment without edge"); // RQ1

  property p_tmr_clr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && dp_wr_q && dp_addr_q == TPW_OFF_CTRL && hwdata[TPW_CTRL_TMRWR_BIT] && !prescaler_assign_sel)
      |=> (pre_cnt == '0);
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer write kept prescaler"); // RQ7

  property p_wd_clr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && wd_clr_stb && prescaler_assign_sel) |=> (pre_cnt == '0) && (base_q == '0) && !wdt_device_reset;
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("watchdog clear incomplete"); // RQ8

  property p_fuse_off;
    @(posedge hclk) disable iff (!hresetn)
    (!wdt_enabled && ce) |=> !wdt_device_reset;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("reset with watchdog disabled"); // RQ12

  property p_to_flag;
    @(posedge hclk) disable iff (!hresetn)
    wdt_device_reset |-> !to_flag_q;
  endproperty
  a_to_flag: assert property (p_to_flag) else $error("timeout flag not cleared"); // RQ17

  property p_osc_dec;
    @(posedge hclk) disable iff (!hresetn)
    ce ##1 $stable(cfg_word) |-> osc_type == cfg_word[1:0];
  endproperty
  a_osc_dec: assert property (p_osc_dec) else $error("oscillator type mismatch"); // RQ13

  property p_reduced;
    @(posedge hclk) disable iff (!hresetn)
    (ce && cfg_reduced && addr_ok && !hwrite && haddr == TPW_OFF_CONFIG)
      |=> (hrdata[TPW_CFG_CP_MSB:TPW_CFG_CP_LSB+1] == '0);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced config bits set"); // RQ14

  property p_one_user;
    @(posedge hclk) disable iff (!hresetn)
    (ce && prescaler_assign_sel && !base_end && !pre_clr) |=> $stable(pre_cnt);
  endproperty
  a_one_user: assert property (p_one_user) else $error("prescaler shared"); // RQ5

  property p_no_post;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !prescaler_assign_sel && base_end) |=> wdt_device_reset;
  endproperty
  a_no_post: assert property (p_no_post) else $error("watchdog divided while timer owns prescaler"); // RQ5

  c_inc:     cover property (@(posedge hclk) disable iff (!hresetn) timer_inc);
  c_wdreset: cover property (@(posedge hclk) disable iff (!hresetn) wdt_device_reset && prescaler_assign_sel);
  c_tmrclr:  cover property (@(posedge hclk) disable iff (!hresetn) tmr_wr_stb && !prescaler_assign_sel && ce);

endmodule
`default_nettype wire

// ==== verification/tpw_ext_src.sv ====
// Purpose: external count source that drives the timer input pin
// Assumes: paced by hclk edges; one hclk period is one oscillator period
// Notes:   the pin rests low between bursts, as an idle source would
`timescale 1ns/10ps
`default_nettype none
module tpw_ext_src (
  input  wire logic       hclk,
  input  wire logic       start,
  input  wire logic [9:0] n_pulses,
  input  wire logic [3:0] hi_cyc,
  output logic            pin,
  output logic            busy
);
  ////////////////////////////////////////////////////////////
  // burst of pulses; widths are clamped so no level is ever too short to sample
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (start)
      begin
        busy <= 1'b1;
        repeat (n_pulses)
        begin
          pin <= 1'b1;
          repeat ((hi_cyc < 4'h2) ? 2 : hi_cyc) @(posedge hclk);
          pin <= 1'b0;
          repeat ((hi_cyc < 4'h2) ? 2 : hi_cyc) @(posedge hclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tpw_tb_top.sv ====
// Purpose: self-checking bench for the timer prescaler and watchdog block
// Assumes: zero-wait register bus; watchdog oscillator scaled to 1 kHz
// Notes:   expectations come from bench functions, never from the design
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module tpw_tb_top
  import tpw_pkg::*;
;
  localparam int WDT_HZ = 1000;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_pin;
  logic        wdt_osc = 1'b0;
  logic [11:0] cfg_word = 12'hFF3;
  logic        cfg_reduced = 1'b0;
  logic        timer_inc;
  logic        wdt_rst;
  logic [1:0]  osc_type;
  logic        cp_on;
  logic        wdt_en;
  logic        src_start = 1'b0;
  logic [9:0]  src_n = 10'h0;
  logic [3:0]  src_hi = 4'h2;
  logic        src_busy;
  logic        direct = 1'b0;
  logic        pin_d = 1'b0;
  int          since = 0;
  int          inc_cnt = 0;
  int          rst_cnt = 0;
  int          fails = 0;
  int          check_count = 0;
  int          seed = 32'hEACD68AD;

  ////////////////////////////////////////////////////////////
  // clock and design under test; watchdog rate lowered to keep the run short
  always #4 hclk = ~hclk;

  tpw_top #(.WDT_OSC_HZ(WDT_HZ), .PRE_W(TPW_PRE_W)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_ext_clock_pin(ext_pin), .wdt_osc_pin(wdt_osc), .cfg_word(cfg_word),
    .cfg_reduced(cfg_reduced), .timer_inc(timer_inc), .wdt_device_reset(wdt_rst),
    .osc_type(osc_type), .code_protect_on(cp_on), .wdt_enabled(wdt_en)
  );

  tpw_ext_src src_u (
    .hclk(hclk), .start(src_start), .n_pulses(src_n), .hi_cyc(src_hi),
    .pin(ext_pin), .busy(src_busy)
  );

  ////////////////////////////////////////////////////////////
  // event counters and increment latency, measured from the pin rise
  always @(posedge hclk)
  begin
    if (timer_inc === 1'b1 && direct)
      `CHK((since + 1 >= TPW_INC_MIN_TOSC) && (since + 1 <= TPW_INC_MAX_TOSC), 1'b1)
    since <= (ext_pin && !pin_d) ? 0 : since + 1;
    pin_d <= ext_pin;
    inc_cnt <= inc_cnt + (timer_inc === 1'b1);
    rst_cnt <= rst_cnt + (wdt_rst === 1'b1);
  end

  ////////////////////////////////////////////////////////////
  // bus cycles: address phase held until hready, data taken at the next edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e)
    `CHK(hresp, 1'b0)
  endtask

  // watchdog oscillator ticks, four cycles high and four low
  task automatic tick(input int n);
    repeat (n)
    begin
      wdt_osc <= 1'b1;
      repeat (4) @(posedge hclk);
      wdt_osc <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  // one burst from the source, then time for the last increment to land
  task automatic pulses(input int n, input int hi);
    src_n <= n[9:0];
    src_hi <= hi[3:0];
    src_start <= 1'b1;
    @(posedge hclk);
    src_start <= 1'b0;
    repeat (2) @(posedge hclk);
    while (src_busy === 1'b1) @(posedge hclk);
    repeat (10) @(posedge hclk);
  endtask

  function automatic int exp_inc(input int p, input int n, input logic dir);
    return dir ? p : (p + (1 << n)) >> (n + 1);
  endfunction

  function automatic int wd_ticks(input logic asg, input int n);
    return (TPW_WDT_NOM_MS * WDT_HZ / 1000) << (asg ? n : 0);
  endfunction

  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence: registers, configuration, timer path, watchdog
  initial
  begin
    logic [31:0] r;
    logic [11:0] c;
    logic        dir;
    int          p;
    int          c0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(TPW_OFF_OPTION, 32'h3F);
    bus(1'b0, TPW_OFF_STATUS, 32'h0, r);
    `CHK(r[TPW_STAT_TO_BIT], TPW_TO_RST)
    rd_chk(TPW_OFF_CTRL, 32'h0);
    rd_chk(8'h10, 32'h0);
    r = $random(seed);
    wr(TPW_OFF_OPTION, r);
    rd_chk(TPW_OFF_OPTION, r & 32'h3F);
    for (int i = 0; i < 8; i++)
    begin
      c = (i == 3) ? 12'hFFF : 12'($random(seed));
      c[1:0] = i[1:0];
      cfg_word <= c;
      cfg_reduced <= i[2];
      repeat (3) @(posedge hclk);
      `CHK(osc_type, c[1:0])
      `CHK(wdt_en, c[2])
      `CHK(cp_on, i[2] ? ~c[3] : (c[11:3] != 9'h1FF))
      rd_chk(TPW_OFF_CONFIG, i[2] ? {28'h0, c[3:0]} : {20'h0, c});
    end
    cfg_word <= 12'hFF3;
    cfg_reduced <= 1'b0;
    for (int m = 0; m < 9; m++)
    begin
      dir = (m == 8);
      wr(TPW_OFF_CTRL, 32'h2);
      wr(TPW_OFF_OPTION, {28'h0, dir, m[2:0]});
      rd_chk(TPW_OFF_OPTION, {28'h0, dir, m[2:0]});
      if (m != 0)
      begin
        pulses(1 + $unsigned($random(seed)) % 3, 2);
        wr(TPW_OFF_CTRL, 32'h1);
      end
      direct = dir;
      c0 = inc_cnt;
      p = 1 + $unsigned($random(seed)) % 300;
      pulses(p, (dir ? 4 : 2) + $unsigned($random(seed)) % 3);
      `CHK(inc_cnt - c0, exp_inc(p, m, dir))
      direct = 1'b0;
    end
    cfg_word <= 12'hFFF;
    for (int k = 0; k < 4; k++)
    begin
      wr(TPW_OFF_CTRL, 32'h2);
      wr(TPW_OFF_CTRL, 32'h1);
      wr(TPW_OFF_OPTION, {28'h0, k != 3, k[2:0]});
      wr(TPW_OFF_CTRL, 32'h2);
      c0 = rst_cnt;
      tick(wd_ticks(k != 3, k) - 1);
      `CHK(rst_cnt - c0, 0)
      tick(1);
      `CHK(rst_cnt - c0, 1)
      bus(1'b0, TPW_OFF_STATUS, 32'h0, r);
      `CHK(r[TPW_STAT_TO_BIT], 1'b0)
      wr(TPW_OFF_STATUS, 32'h10);
    end
    bus(1'b0, TPW_OFF_STATUS, 32'h0, r);
    `CHK(r[TPW_STAT_TO_BIT], 1'b1)
    wr(TPW_OFF_OPTION, 32'h9);
    wr(TPW_OFF_CTRL, 32'h2);
    c0 = rst_cnt;
    tick(20);
    wr(TPW_OFF_CTRL, 32'h2);
    tick(35);
    `CHK(rst_cnt - c0, 0)
    cfg_word <= 12'hFFB;
    tick(40);
    `CHK(rst_cnt - c0, 0)
    end_of_test;
  end

  // hang guard, about twice the longest expected run of some 25000 cycles
  initial
  begin
    #400000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
